// file: rtl/itest_pkg.sv
// Constants for the trace buffer integration test register bank
package itest_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_MODE_CTRL = 12'h0F00;
   localparam logic [11:0] OFS_MISC_OUT = 12'h0EE0;
   localparam logic [11:0] OFS_ACK_DRIVE = 12'h0EE4;
   localparam logic [11:0] OFS_IN_SAMPLE = 12'h0EE8;
   localparam logic [11:0] OFS_DATA_SAMPLE = 12'h0EEC;
   localparam logic [11:0] OFS_HS_DRIVE = 12'h0EF0;
   localparam int ADDR_W = 12;
   // Field positions
   localparam int BIT_ACQ = 0;
   localparam int BIT_FULL = 1;
   localparam int BIT_TRIG_ACK = 0;
   localparam int BIT_FLUSH_ACK = 1;
   localparam int BIT_TRIG = 0;
   localparam int BIT_FLUSH = 1;
   localparam int BIT_READY = 0;
   localparam int BIT_FVALID = 1;
   localparam int BIT_IME = 0;
   localparam int DATA_W = 32;
   localparam int SAMPLE_W = 5;
   // Trace data bits picked for sampling, low register bit first
   localparam int TAP0 = 0;
   localparam int TAP1 = 7;
   localparam int TAP2 = 15;
   localparam int TAP3 = 23;
   localparam int TAP4 = 31;
   localparam logic [1:0] RST_PAIR = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : itest_pkg

// file: rtl/itest_wr_if.sv
// Write strobe carrier between bus slave and register bank
`timescale 1ns/1ps
interface itest_wr_if;
   logic we;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [11:0] raddr;
   logic [31:0] rdata;
   modport slave (output we, output addr, output wdata, output raddr, input rdata);
   modport bank (input we, input addr, input wdata, input raddr, output rdata);
endinterface : itest_wr_if

// file: rtl/itest_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module itest_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] stage1;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= '0;
         o_q <= '0;
      end else begin
         stage1 <= i_d;
         o_q <= stage1;
      end
   end
endmodule : itest_sync

// file: rtl/itest_ahb.sv
// AHB-Lite slave front end for the test register bank
`timescale 1ns/1ps
module itest_ahb (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   itest_wr_if.slave wr
);
   logic wr_pend;
   logic [11:0] wr_addr;
   logic rd_now;

   // Address phase accepted: word transfer only
   assign rd_now = i_hsel && i_hready && i_htrans[1] && !i_hwrite
      && (i_hsize == itest_pkg::HSIZE_WORD);
   assign wr.we = wr_pend;
   assign wr.addr = wr_addr;
   assign wr.wdata = i_hwdata;
   assign wr.raddr = i_haddr;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         o_hrdata <= itest_pkg::ZERO_WORD;
      end else begin
         wr_pend <= i_hsel && i_hready && i_htrans[1] && i_hwrite
            && (i_hsize == itest_pkg::HSIZE_WORD);
         wr_addr <= i_haddr;
         o_hrdata <= rd_now ? wr.rdata : itest_pkg::ZERO_WORD;
      end
   end
endmodule : itest_ahb

// file: rtl/trace_buffer_integration_test.sv
// Integration test register bank of the trace buffer
`timescale 1ns/1ps
// What this block does
// - Writing the misc output register drives full from bit 1 and acquisition-complete from bit 0.
// - Bit 1 of the acknowledge register sets the flush-request acknowledge output level.
// - Bit 0 of the acknowledge register sets the trigger acknowledge output level.
// - The input sample register reads flush request in bit 1 and trigger in bit 0.
// - The trace data sample register reads data bits 31,23,15,7,0 in bits 4 to 0.
// - The handshake register drives flush-valid from bit 1 and trace-ready from bit 0.
// - All test registers exist in every build, with no option to remove them.
// - Test registers control the pins only while integration mode is enabled.
module trace_buffer_integration_test (
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   input wire logic I_HSEL,
   input wire logic [11:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic I_HREADY,
   input wire logic [31:0] I_HWDATA,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   input wire logic I_FUNC_FULL,
   input wire logic I_FUNC_ACQ_DONE,
   input wire logic I_FUNC_TRIG_ACK,
   input wire logic I_FUNC_FLUSH_ACK,
   input wire logic I_FUNC_TRACE_READY,
   input wire logic I_FUNC_FLUSH_VALID,
   input wire logic I_TRIG,
   input wire logic I_FLUSH_REQ,
   input wire logic [31:0] I_TRACE_DATA,
   input wire logic I_TRACE_VALID,
   output logic O_INTEG_MODE,
   output logic O_FULL,
   output logic O_ACQ_DONE,
   output logic O_TRIG_ACK,
   output logic O_FLUSH_ACK,
   output logic O_TRACE_READY,
   output logic O_FLUSH_VALID
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   itest_wr_if wr ();
   logic integration_mode_enable;
   logic [1:0] misc_output_drive;
   logic [1:0] trigger_flush_ack_drive;
   logic [1:0] trace_handshake_output_drive;
   logic [1:0] pin_pair;
   logic [1:0] trigger_flush_input_sample;
   logic [4:0] tap_raw;
   logic [4:0] trace_data_bit_sample;
   logic [31:0] read_word;
   logic [31:0] unused_valid;

   function automatic logic [31:0] low2(input logic [1:0] v);
      low2 = {30'h0000_0000, v};
   endfunction : low2

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end
   itest_ahb u_ahb (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESETN),
      .i_hsel(I_HSEL),
      .i_haddr(I_HADDR),
      .i_htrans(I_HTRANS),
      .i_hwrite(I_HWRITE),
      .i_hsize(I_HSIZE),
      .i_hready(I_HREADY),
      .i_hwdata(I_HWDATA),
      .o_hrdata(O_HRDATA),
      .wr(wr.slave)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   assign pin_pair = {I_FLUSH_REQ, I_TRIG};
   itest_sync #(.W(2)) u_sync_pair (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESETN),
      .i_d(pin_pair),
      .o_q(trigger_flush_input_sample)
   );
   assign tap_raw = {I_TRACE_DATA[itest_pkg::TAP4], I_TRACE_DATA[itest_pkg::TAP3],
      I_TRACE_DATA[itest_pkg::TAP2], I_TRACE_DATA[itest_pkg::TAP1],
      I_TRACE_DATA[itest_pkg::TAP0]};
   itest_sync #(.W(5)) u_sync_data (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESETN),
      .i_d(tap_raw),
      .o_q(trace_data_bit_sample)
   );
   assign unused_valid = {31'h0000_0000, I_TRACE_VALID};

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes
   // always present
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         integration_mode_enable <= 1'b0;
         misc_output_drive <= itest_pkg::RST_PAIR;
         trigger_flush_ack_drive <= itest_pkg::RST_PAIR;
         trace_handshake_output_drive <= itest_pkg::RST_PAIR;
      end else if (wr.we) begin
         unique case (wr.addr)
            itest_pkg::OFS_MODE_CTRL: begin
               integration_mode_enable <= wr.wdata[itest_pkg::BIT_IME];
            end
            itest_pkg::OFS_MISC_OUT: begin
               misc_output_drive <= wr.wdata[1:0];
            end
            itest_pkg::OFS_ACK_DRIVE: begin
               trigger_flush_ack_drive <= wr.wdata[1:0];
            end
            itest_pkg::OFS_HS_DRIVE: begin
               trace_handshake_output_drive <= wr.wdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads
   // read mux
   assign read_word =
      (wr.raddr == itest_pkg::OFS_MODE_CTRL) ? low2({1'b0, integration_mode_enable}) :
      (wr.raddr == itest_pkg::OFS_IN_SAMPLE) ? low2(trigger_flush_input_sample) :
      (wr.raddr == itest_pkg::OFS_DATA_SAMPLE) ? {27'h000_0000, trace_data_bit_sample} :
      itest_pkg::ZERO_WORD;
   assign wr.rdata = read_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Output pins
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         O_INTEG_MODE <= 1'b0;
         O_FULL <= 1'b0;
         O_ACQ_DONE <= 1'b0;
         O_TRIG_ACK <= 1'b0;
         O_FLUSH_ACK <= 1'b0;
         O_TRACE_READY <= 1'b0;
         O_FLUSH_VALID <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         O_INTEG_MODE <= integration_mode_enable;
         if (integration_mode_enable) begin
            O_FULL <= misc_output_drive[itest_pkg::BIT_FULL];
            O_ACQ_DONE <= misc_output_drive[itest_pkg::BIT_ACQ];
            O_TRIG_ACK <= trigger_flush_ack_drive[itest_pkg::BIT_TRIG_ACK];
            O_FLUSH_ACK <= trigger_flush_ack_drive[itest_pkg::BIT_FLUSH_ACK];
            O_TRACE_READY <= trace_handshake_output_drive[itest_pkg::BIT_READY];
            O_FLUSH_VALID <= trace_handshake_output_drive[itest_pkg::BIT_FVALID];
         end else begin
            O_FULL <= I_FUNC_FULL;
            O_ACQ_DONE <= I_FUNC_ACQ_DONE;
            O_TRIG_ACK <= I_FUNC_TRIG_ACK;
            O_FLUSH_ACK <= I_FUNC_FLUSH_ACK;
            O_TRACE_READY <= I_FUNC_TRACE_READY;
            O_FLUSH_VALID <= I_FUNC_FLUSH_VALID;
         end
      end
   end
endmodule : trace_buffer_integration_test

// file: bench/itest_assertions.sv
// Concurrent checks on the ports of the integration test register bank
`timescale 1ns/1ps
module itest_assertions (
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   input wire logic I_HSEL,
   input wire logic [11:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic I_HREADY,
   input wire logic [31:0] I_HWDATA,
   input wire logic [31:0] O_HRDATA,
   input wire logic O_HREADYOUT,
   input wire logic O_HRESP,
   input wire logic I_FUNC_FULL,
   input wire logic I_FUNC_TRIG_ACK,
   input wire logic I_TRIG,
   input wire logic I_FLUSH_REQ,
   input wire logic [31:0] I_TRACE_DATA,
   input wire logic I_TRACE_VALID,
   input wire logic O_INTEG_MODE,
   input wire logic O_FULL,
   input wire logic O_ACQ_DONE,
   input wire logic O_TRIG_ACK,
   input wire logic O_FLUSH_ACK,
   input wire logic O_TRACE_READY,
   input wire logic O_FLUSH_VALID
);
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   wire logic [1:0] in_pair = {I_FLUSH_REQ, I_TRIG};
   wire logic [4:0] taps = {I_TRACE_DATA[31], I_TRACE_DATA[23], I_TRACE_DATA[15],
      I_TRACE_DATA[7], I_TRACE_DATA[0]};
   sequence s_acc(ofs, wr);
      I_HSEL && I_HREADY && I_HTRANS[1] && I_HSIZE == 3'h2 && I_HWRITE == wr && I_HADDR == ofs;
   endsequence
   property p_drive(ofs, pin, b);
      s_acc(ofs, 1'b1) ##1 O_INTEG_MODE [*3] |-> pin == $past(I_HWDATA[b], 2);
   endproperty
   a_full_drive: assert property (p_drive(itest_pkg::OFS_MISC_OUT, O_FULL, 1))
      else $error("full pin differs from written bit");
   a_acq_drive: assert property (p_drive(itest_pkg::OFS_MISC_OUT, O_ACQ_DONE, 0))
      else $error("acquisition pin differs from written bit");
   a_flush_ack: assert property (p_drive(itest_pkg::OFS_ACK_DRIVE, O_FLUSH_ACK, 1))
      else $error("flush ack pin differs from written bit");
   a_trig_ack: assert property (p_drive(itest_pkg::OFS_ACK_DRIVE, O_TRIG_ACK, 0))
      else $error("trigger ack pin differs from written bit");
   a_flush_valid: assert property (p_drive(itest_pkg::OFS_HS_DRIVE, O_FLUSH_VALID, 1))
      else $error("flush valid pin differs from written bit");
   a_trace_ready: assert property (p_drive(itest_pkg::OFS_HS_DRIVE, O_TRACE_READY, 0))
      else $error("trace ready pin differs from written bit");
   a_input_sample: assert property (s_acc(itest_pkg::OFS_IN_SAMPLE, 1'b0) |->
      ##1 O_HRDATA == {30'h0000_0000, $past(in_pair, 4)}) else $error("input sample wrong");
   a_data_taps: assert property (s_acc(itest_pkg::OFS_DATA_SAMPLE, 1'b0) && I_TRACE_VALID
      |-> ##1 O_HRDATA == {27'h000_0000, $past(taps, 4)}) else $error("data sample wrong");
   a_reserved_zero: assert property (s_acc(itest_pkg::OFS_MODE_CTRL, 1'b0) |->
      ##1 O_HRDATA[31:1] == 31'h0000_0000) else $error("reserved bits not zero");
   a_mode_mirror: assert property (s_acc(itest_pkg::OFS_MODE_CTRL, 1'b1) |->
      ##2 O_INTEG_MODE == $past(I_HWDATA[0])) else $error("mode pin differs from written bit");
   a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
      else $error("bus not ready or response not okay");
   a_func_pass: assert property (!O_INTEG_MODE [*3] |-> O_FULL == $past(I_FUNC_FULL)
      && O_TRIG_ACK == $past(I_FUNC_TRIG_ACK)) else $error("pins ignore functional values");
endmodule : itest_assertions
bind trace_buffer_integration_test itest_assertions itest_assertions_i (.*);

// file: bench/trace_source_model.sv
// Upstream trace source and trigger logic feeding the bank
`timescale 1ns/1ps
module trace_source_model (
   input wire logic i_clk,
   input wire logic i_valid,
   input wire logic [33:0] i_word,
   output logic o_flush = 1'b0,
   output logic o_trig = 1'b0,
   output logic [31:0] o_data = 32'h0000_0000,
   output logic o_valid = 1'b0
);
   always @(posedge i_clk) begin
      o_valid <= i_valid;
      if (i_valid) begin
         {o_flush, o_trig, o_data} <= i_word;
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule : trace_source_model

// file: bench/trace_buffer_integration_test_test.sv
// Self-checking bench for the integration test register bank
`timescale 1ns/1ps
module trace_buffer_integration_test_test;
   logic I_SYS_CLK = 1'b0;
   logic I_RESETN = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, r, m, a, h, d;
   logic [5:0] func = 6'h00;
   logic [5:0] pins;
   logic hready, trig, flush, valid;
   logic src_v = 1'b0;
   logic rd_dp = 1'b0;
   logic pin_req = 1'b0;
   logic [33:0] src_w = 34'h0_0000_0000;
   logic [31:0] tdata;
   logic [31:0] exp_q[$];
   logic [5:0] pin_q[$];
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   initial forever #20 I_SYS_CLK = ~I_SYS_CLK;
   trace_source_model trace_source_model_i (.i_clk(I_SYS_CLK), .i_valid(src_v),
      .i_word(src_w), .o_flush(flush), .o_trig(trig), .o_data(tdata), .o_valid(valid));
   trace_buffer_integration_test trace_buffer_integration_test_i (.I_SYS_CLK(I_SYS_CLK),
      .I_RESETN(I_RESETN), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(itest_pkg::HSIZE_WORD), .I_HREADY(hready),
      .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
      .I_FUNC_FULL(func[5]), .I_FUNC_ACQ_DONE(func[4]), .I_FUNC_FLUSH_ACK(func[3]),
      .I_FUNC_TRIG_ACK(func[2]), .I_FUNC_FLUSH_VALID(func[1]), .I_FUNC_TRACE_READY(func[0]),
      .I_TRIG(trig), .I_FLUSH_REQ(flush), .I_TRACE_DATA(tdata), .I_TRACE_VALID(valid),
      .O_INTEG_MODE(), .O_FULL(pins[5]), .O_ACQ_DONE(pins[4]), .O_FLUSH_ACK(pins[3]),
      .O_TRIG_ACK(pins[2]), .O_FLUSH_VALID(pins[1]), .O_TRACE_READY(pins[0]));
   task automatic test_done();
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      checks_done++;
      if (got !== e) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, e);
      end
   endtask : cmp
   task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] dt);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= wr;
      htrans <= itest_pkg::HTRANS_NONSEQ;
      do @(posedge I_SYS_CLK); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= dt;
      do @(posedge I_SYS_CLK); while (hready !== 1'b1);
   endtask : xfer
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, ad, 32'h0000_0000);
   endtask : rd
   task automatic pins_are(input logic [5:0] e);
      repeat (2) @(posedge I_SYS_CLK);
      pin_q.push_back(e);
      pin_req <= 1'b1;
      @(posedge I_SYS_CLK);
      pin_req <= 1'b0;
   endtask : pins_are
   always @(posedge I_SYS_CLK) begin
      if (rd_dp && hready === 1'b1) cmp(hrdata, exp_q.pop_front());
      if (pin_req) cmp({26'h000_0000, pins}, {26'h000_0000, pin_q.pop_front()});
      rd_dp <= hsel && htrans[1] && !hwrite && hready === 1'b1;
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      void'($urandom(20));
      repeat (10) @(posedge I_SYS_CLK);
      I_RESETN <= 1'b1;
      r = $urandom;
      func <= r[5:0];
      pins_are(r[5:0]);
      rd(itest_pkg::OFS_MODE_CTRL, 32'h0000_0000);
      xfer(1'b1, itest_pkg::OFS_MODE_CTRL, r | 32'h0000_0001);
      rd(itest_pkg::OFS_MODE_CTRL, 32'h0000_0001);
      repeat (8) begin
         m = $urandom;
         a = $urandom;
         h = $urandom;
         func <= m[7:2];
         xfer(1'b1, itest_pkg::OFS_MISC_OUT, m);
         xfer(1'b1, itest_pkg::OFS_ACK_DRIVE, a);
         xfer(1'b1, itest_pkg::OFS_HS_DRIVE, h);
         pins_are({m[1:0], a[1:0], h[1:0]});
         rd(itest_pkg::OFS_HS_DRIVE, 32'h0000_0000);
      end
      rd(12'hef4, 32'h0000_0000);
      repeat (8) begin
         d = $urandom;
         r = $urandom;
         src_w <= {r[1:0], d};
         src_v <= 1'b1;
         repeat (6) @(posedge I_SYS_CLK);
         rd(itest_pkg::OFS_IN_SAMPLE, {30'h0000_0000, r[1:0]});
         rd(itest_pkg::OFS_DATA_SAMPLE, {27'h000_0000, d[31], d[23], d[15], d[7], d[0]});
      end
      src_v <= 1'b0;
      xfer(1'b1, itest_pkg::OFS_MODE_CTRL, 32'h0000_0000);
      r = $urandom;
      func <= r[5:0];
      pins_are(r[5:0]);
      test_done();
   end
endmodule : trace_buffer_integration_test_test
